//--- logic/cwd_config_decode.sv
// Notes on behaviour
// R1 - word one bit 13 enables the clock monitor.
// R2 - word one bit 12 enables internal/external clock switchover.
// R3 - bit 11 low drives clock out on shared pin, high leaves it I/O.
// R4 - bits 10-9 choose brown-out: always, running only, software, off.
// R5 - reset-pin select ignored under low-voltage programming; else reset or input.
// R6 - bit 5 low enables the power-up timer.
// R7 - bits 4-3 choose watchdog: always, running only, software, off.
// R8 - power-up timer follows only its own bit, never brown-out.
// R9 - bits 2-0 select external clock, internal, RC or crystal modes.
// R10 - word two bit 9 makes stack faults cause reset.
// R11 - word two bit 8 enables the four-times multiplier.
// R12 - bits 5-4 place regulator capacitor on A0, A5, A6 or none.
// R13 - 4K part: self-write protect covers 1FFh, 7FFh, FFFh or nothing.
// R14 - 8K part: self-write protect covers 1FFh, FFFh, 1FFFh or nothing.
// R15 - debugger bit low dedicates programming pins to the debugger.
// R16 - low-voltage enable cannot be cleared when entered through low-voltage mode.
// R17 - unimplemented bits of word two read as one.
// R18 - program protect blocks external program writes, reads give zero.
// R19 - data protect blocks external data EEPROM reads and writes.
// R20 - internal accesses ignore protection; program self-writes see write protect.
// R21 - clearing protection erases program memory, or data during an erase.
// R22 - read-only identity word at 8006h: part code high, revision low.
// R23 - word one at 8007h, word two at 8008h.
// R24 - words latched during reset, settings held until next reset; the code latches them at the first enabled clock after reset release.
// R25 - blank storage reads as all ones.
//
// Design decision made here: the Wishbone slave port.
`default_nettype none
module cwd_config_decode
    import cwd_pkg::*;
(
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    input  wire logic             clkEn,
    input  wire logic [13:0]      nvmWordOne,
    input  wire logic [13:0]      nvmWordTwo,
    input  wire logic             nvmBlank,
    input  wire logic             largeMemory,
    input  wire logic             enteredViaLowVoltage,
    input  wire logic             progWriteCfg,
    input  wire logic             progWriteSel,
    input  wire logic [13:0]      progWriteData,
    input  wire logic             bulkEraseActive,
    input  wire cwd_access_type   accessReq,
    input  wire logic [31:0]      wb_adr_i,
    input  wire logic [31:0]      wb_dat_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic             wb_we_i,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    output logic [31:0]           wb_dat_o,
    output logic                  wb_ack_o,
    output logic                  wb_err_o,
    output cwd_settings_type      settings,
    output logic                  accessGrant,
    output logic                  readZero,
    output logic                  cfgWriteStrobe,
    output logic [13:0]           cfgWriteValue,
    output logic                  eraseProgram,
    output logic                  eraseData
);

    // ****************************************
    // latch of the stored words
    // ****************************************
    logic [13:0]      wordOne_reg;
    logic [13:0]      wordTwo_reg;
    logic             loaded_reg;
    logic [13:0]      wordOneSrc;
    logic [13:0]      wordTwoSrc;

    assign wordOneSrc = nvmBlank ? CWD_BLANK_WORD : nvmWordOne;                 // R25
    assign wordTwoSrc = (nvmBlank ? CWD_BLANK_WORD : nvmWordTwo) | CWD_C2_UNIMPL; // R17

    // captured once after release; constants only under reset
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wordOne_reg <= CWD_BLANK_WORD;
            wordTwo_reg <= CWD_BLANK_WORD;
            loaded_reg  <= 1'b0;
        end else if (clkEn && !loaded_reg) begin
            wordOne_reg <= wordOneSrc;  // R24
            wordTwo_reg <= wordTwoSrc;  // R24
            loaded_reg  <= 1'b1;
        end
    end

    // ****************************************
    // decode of the settings
    // ****************************************
    cwd_settings_type settingsNext;
    logic             low_voltage_program_enable;
    logic             rstSel;

    assign low_voltage_program_enable    = wordTwo_reg[CWD_C2_LVP];
    assign rstSel = wordOne_reg[CWD_C1_RST];

    always_comb begin
        settingsNext = '0;
        settingsNext.clockMonitorEnable    = wordOne_reg[CWD_C1_MON];        // R1
        settingsNext.clockSwitchoverEnable = wordOne_reg[CWD_C1_SWO];        // R2
        settingsNext.clockOutputDrive      = !wordOne_reg[CWD_C1_CKO];       // R3
        settingsNext.brownoutMode = cwd_mode_decode(wordOne_reg[CWD_C1_BRO +: 2]); // R4
        settingsNext.resetPinIsReset  = low_voltage_program_enable | rstSel;                        // R5
        settingsNext.resetPinPullup   = low_voltage_program_enable | rstSel;                        // R5
        settingsNext.resetPinPullupByControl = !low_voltage_program_enable && !rstSel;              // R5
        settingsNext.powerupTimerOn   = !wordOne_reg[CWD_C1_PUT];            // R6 R8
        settingsNext.watchdogMode = cwd_mode_decode(wordOne_reg[CWD_C1_WDG +: 2]); // R7
        case (wordOne_reg[CWD_C1_OSC +: 3])                                  // R9
            3'h7:    settingsNext.oscillatorSource = CWD_OSC_ECH;
            3'h6:    settingsNext.oscillatorSource = CWD_OSC_ECM;
            3'h5:    settingsNext.oscillatorSource = CWD_OSC_ECL;
            3'h4:    settingsNext.oscillatorSource = CWD_OSC_INT;
            3'h3:    settingsNext.oscillatorSource = CWD_OSC_RC;
            3'h2:    settingsNext.oscillatorSource = CWD_OSC_XHS;
            3'h1:    settingsNext.oscillatorSource = CWD_OSC_XMD;
            default: settingsNext.oscillatorSource = CWD_OSC_XLP;
        endcase
        settingsNext.lowVoltageProgramEnable = low_voltage_program_enable;
        settingsNext.debuggerOwnsPins      = !wordTwo_reg[CWD_C2_DBG];       // R15
        settingsNext.brownoutLevelSelect   = wordTwo_reg[CWD_C2_BLV];
        settingsNext.stackFaultResetEnable = wordTwo_reg[CWD_C2_STK];        // R10
        settingsNext.multiplierEnable      = wordTwo_reg[CWD_C2_PLL];        // R11
        case (wordTwo_reg[CWD_C2_CAP +: 2])                                  // R12
            2'b00:   settingsNext.regulatorCapPin = 4'h1;
            2'b01:   settingsNext.regulatorCapPin = 4'h2;
            2'b10:   settingsNext.regulatorCapPin = 4'h4;
            default: settingsNext.regulatorCapPin = 4'h0;
        endcase
        settingsNext.programProtect = !wordOne_reg[CWD_C1_PPR];
        settingsNext.dataProtect    = !wordOne_reg[CWD_C1_DPR];
    end

    assign settings = settingsNext;

    // ****************************************
    // access gate
    // ****************************************
    logic [12:0] writeLimit;
    logic        selfWriteBlocked;
    logic        extBlocked;

    // top protected address plus one; zero means nothing protected
    always_comb begin
        case (wordTwo_reg[CWD_C2_WRP +: 2])
            2'b11:   writeLimit = 13'h0000;
            2'b10:   writeLimit = 13'h0200;                                      // R13 R14
            2'b01:   writeLimit = largeMemory ? 13'h1000 : 13'h0800;             // R13 R14
            default: writeLimit = largeMemory ? 13'h1FFF : 13'h0FFF;             // R13 R14
        endcase
    end

    // the all-protected case covers the top address too
    assign selfWriteBlocked = (wordTwo_reg[CWD_C2_WRP +: 2] == 2'b00) ? 1'b1
                            : (accessReq.addr < writeLimit);
    assign extBlocked = accessReq.isProgram
                      ? (settingsNext.programProtect && accessReq.write)           // R18
                      : settingsNext.dataProtect;                                  // R19
    assign accessGrant = accessReq.req && loaded_reg && (accessReq.external
                       ? !extBlocked
                       : !(accessReq.isProgram && accessReq.write && selfWriteBlocked)); // R20
    assign readZero = accessReq.req && accessReq.external && accessReq.isProgram
                    && !accessReq.write && settingsNext.programProtect;            // R18

    // ****************************************
    // programming of the configuration words
    // ****************************************
    logic        lvpRefuse;
    logic [13:0] writeFixed;

    assign lvpRefuse  = progWriteSel && enteredViaLowVoltage && !progWriteData[CWD_C2_LVP];
    assign writeFixed = progWriteSel
                      ? ((lvpRefuse ? (progWriteData | 14'h2000) : progWriteData)
                         | CWD_C2_UNIMPL)                                          // R16 R17
                      : progWriteData;
    assign cfgWriteStrobe = progWriteCfg && clkEn;
    assign cfgWriteValue  = writeFixed;
    assign eraseProgram = cfgWriteStrobe && !progWriteSel && settingsNext.programProtect
                        && writeFixed[CWD_C1_PPR];                                 // R21
    assign eraseData    = cfgWriteStrobe && !progWriteSel && bulkEraseActive
                        && settingsNext.dataProtect && writeFixed[CWD_C1_DPR];     // R21

    // ****************************************
    // wishbone slave
    // ****************************************
    logic        wbReq;
    logic        hitIdent;
    logic        hitOne;
    logic        hitTwo;
    logic        hitStat;
    logic        mapped;
    logic [31:0] readMux;
    logic [31:0] datOut_reg;
    logic        ack_reg;
    logic        err_reg;
    logic [17:0] adr;

    assign adr      = wb_adr_i[17:0];
    assign wbReq    = wb_cyc_i && wb_stb_i && !ack_reg && !err_reg;
    assign hitIdent = (wb_adr_i[31:18] == 14'h0000) && (adr == CWD_ADR_IDENT);    // R22
    assign hitOne   = (wb_adr_i[31:18] == 14'h0000) && (adr == CWD_ADR_CFG1);     // R23
    assign hitTwo   = (wb_adr_i[31:18] == 14'h0000) && (adr == CWD_ADR_CFG2);     // R23
    assign hitStat  = (wb_adr_i[31:18] == 14'h0000) && (adr == CWD_ADR_STAT);
    assign mapped   = (hitIdent || hitOne || hitTwo || hitStat) && !wb_we_i;

    always_comb begin
        if (hitIdent) begin
            readMux = {18'h00000, CWD_PART_CODE, CWD_REV_CODE};                   // R22
        end else if (hitOne) begin
            readMux = {18'h00000, wordOne_reg};
        end else if (hitTwo) begin
            readMux = {18'h00000, wordTwo_reg};                                   // R17
        end else if (hitStat) begin
            readMux = {31'h00000000, loaded_reg};
        end else begin
            readMux = 32'h00000000;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ack_reg    <= 1'b0;
            err_reg    <= 1'b0;
            datOut_reg <= 32'h00000000;
        end else if (clkEn) begin
            ack_reg    <= wbReq && mapped;
            err_reg    <= wbReq && !mapped;
            datOut_reg <= (wbReq && mapped) ? readMux : 32'h00000000;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_err_o = err_reg;
    assign wb_dat_o = datOut_reg;

endmodule : cwd_config_decode
`default_nettype wire

//--- logic/cwd_pkg.sv
`default_nettype none
package cwd_pkg;

    // ****************************************
    // register offsets (byte addresses, word index times four)
    // ****************************************
    localparam logic [15:0] CWD_IDX_IDENT   = 16'h8006;
    localparam logic [15:0] CWD_IDX_CFG1    = 16'h8007;
    localparam logic [15:0] CWD_IDX_CFG2    = 16'h8008;
    localparam logic [17:0] CWD_ADR_IDENT   = {CWD_IDX_IDENT, 2'b00};
    localparam logic [17:0] CWD_ADR_CFG1    = {CWD_IDX_CFG1, 2'b00};
    localparam logic [17:0] CWD_ADR_CFG2    = {CWD_IDX_CFG2, 2'b00};
    localparam logic [17:0] CWD_ADR_CTRL    = 18'h00000;
    localparam logic [17:0] CWD_ADR_STAT    = 18'h00004;
    localparam logic [17:0] CWD_ADR_ACCESS  = 18'h00008;

    // ****************************************
    // word one fields
    // ****************************************
    localparam int CWD_C1_MON    = 13;
    localparam int CWD_C1_SWO    = 12;
    localparam int CWD_C1_CKO    = 11;
    localparam int CWD_C1_BRO    = 9;
    localparam int CWD_C1_DPR    = 8;
    localparam int CWD_C1_PPR    = 7;
    localparam int CWD_C1_RST    = 6;
    localparam int CWD_C1_PUT    = 5;
    localparam int CWD_C1_WDG    = 3;
    localparam int CWD_C1_OSC    = 0;

    // ****************************************
    // word two fields
    // ****************************************
    localparam int CWD_C2_LVP    = 13;
    localparam int CWD_C2_DBG    = 12;
    localparam int CWD_C2_BLV    = 10;
    localparam int CWD_C2_STK    = 9;
    localparam int CWD_C2_PLL    = 8;
    localparam int CWD_C2_CAP    = 4;
    localparam int CWD_C2_WRP    = 0;
    localparam logic [13:0] CWD_C2_UNIMPL = 14'h08CC;

    // ****************************************
    // reset and blank values
    // ****************************************
    localparam logic [13:0] CWD_BLANK_WORD = 14'h3FFF;
    localparam logic [8:0]  CWD_PART_CODE  = 9'h0A5;  // arbitrary value
    localparam logic [4:0]  CWD_REV_CODE   = 5'h01;   // arbitrary value

    typedef enum logic [3:0] {
        CWD_MODE_OFF   = 4'h1,
        CWD_MODE_SOFT  = 4'h2,
        CWD_MODE_RUN   = 4'h4,
        CWD_MODE_ON    = 4'h8
    } cwd_mode_type;

    typedef enum logic [7:0] {
        CWD_OSC_XLP  = 8'h01,
        CWD_OSC_XMD  = 8'h02,
        CWD_OSC_XHS  = 8'h04,
        CWD_OSC_RC   = 8'h08,
        CWD_OSC_INT  = 8'h10,
        CWD_OSC_ECL  = 8'h20,
        CWD_OSC_ECM  = 8'h40,
        CWD_OSC_ECH  = 8'h80
    } cwd_osc_type;

    typedef struct packed {
        logic         clockMonitorEnable;
        logic         clockSwitchoverEnable;
        logic         clockOutputDrive;
        cwd_mode_type brownoutMode;
        logic         resetPinIsReset;
        logic         resetPinPullup;
        logic         resetPinPullupByControl;
        logic         powerupTimerOn;
        cwd_mode_type watchdogMode;
        cwd_osc_type  oscillatorSource;
        logic         lowVoltageProgramEnable;
        logic         debuggerOwnsPins;
        logic         brownoutLevelSelect;
        logic         stackFaultResetEnable;
        logic         multiplierEnable;
        logic [3:0]   regulatorCapPin;
        logic         programProtect;
        logic         dataProtect;
    } cwd_settings_type;

    typedef struct packed {
        logic        req;
        logic        write;
        logic        external;
        logic        isProgram;
        logic [12:0] addr;
    } cwd_access_type;

    function automatic cwd_mode_type cwd_mode_decode(input logic [1:0] f);
        case (f)
            2'b11:   cwd_mode_decode = CWD_MODE_ON;
            2'b10:   cwd_mode_decode = CWD_MODE_RUN;
            2'b01:   cwd_mode_decode = CWD_MODE_SOFT;
            default: cwd_mode_decode = CWD_MODE_OFF;
        endcase
    endfunction : cwd_mode_decode

endpackage : cwd_pkg
`default_nettype wire

//--- verif/cwd_config_decode_assertions.sv
`default_nettype none
module cwd_config_decode_assertions
    import cwd_pkg::*;
(
    input wire logic             clk_sys,
    input wire logic             resetn,
    input wire logic             clkEn,
    input wire logic             progWriteCfg,
    input wire logic             progWriteSel,
    input wire logic             enteredViaLowVoltage,
    input wire cwd_access_type   accessReq,
    input wire logic [31:0]      wb_adr_i,
    input wire logic             wb_we_i,
    input wire logic             wb_cyc_i,
    input wire logic             wb_stb_i,
    input wire logic [31:0]      wb_dat_o,
    input wire logic             wb_ack_o,
    input wire logic             wb_err_o,
    input wire cwd_settings_type settings,
    input wire logic             accessGrant,
    input wire logic             cfgWriteStrobe,
    input wire logic [13:0]      cfgWriteValue
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // ****************************************
    // properties
    // ****************************************
    sequence s_take;
        wb_cyc_i && wb_stb_i && clkEn && !wb_ack_o && !wb_err_o;
    endsequence
    sequence s_rd(logic [31:0] a);
        s_take ##0 (!wb_we_i && wb_adr_i == a);
    endsequence
    property p_answer; s_take |=> (wb_ack_o ^ wb_err_o); endproperty
    property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
    property p_idle; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o && !wb_err_o; endproperty
    property p_wr_err; s_take ##0 wb_we_i |=> wb_err_o && !wb_ack_o; endproperty
    property p_ident;
        s_rd({14'h0, CWD_ADR_IDENT}) |=> wb_dat_o == {18'h0, CWD_PART_CODE, CWD_REV_CODE};
    endproperty
    property p_unimpl;
        s_rd({14'h0, CWD_ADR_CFG2}) |=> (wb_dat_o[13:0] & CWD_C2_UNIMPL) == CWD_C2_UNIMPL;
    endproperty
    property p_hold; resetn && $past(resetn, 2) |-> $stable(settings); endproperty
    property p_lvp;
        progWriteCfg && progWriteSel && enteredViaLowVoltage && clkEn
            |-> cfgWriteStrobe && cfgWriteValue[13];
    endproperty
    property p_internal;
        accessReq.req && !accessReq.external && !accessReq.isProgram |-> accessGrant;
    endproperty
    a_answer: assert property (p_answer) else $error("no single answer to request");
    a_ack_one: assert property (p_ack_one) else $error("ack held too long");
    a_idle: assert property (p_idle) else $error("answer without request");
    a_wr_err: assert property (p_wr_err) else $error("write not refused");
    a_ident: assert property (p_ident) else $error("identity word wrong");
    a_unimpl: assert property (p_unimpl) else $error("unused bits not one");
    a_hold: assert property (p_hold) else $error("settings moved");
    a_lvp: assert property (p_lvp) else $error("low voltage enable cleared");
    a_internal: assert property (p_internal) else $error("internal data refused");
endmodule : cwd_config_decode_assertions
bind cwd_config_decode cwd_config_decode_assertions u_chk (.clk_sys(clk_sys), .resetn(resetn),
    .clkEn(clkEn), .progWriteCfg(progWriteCfg), .progWriteSel(progWriteSel),
    .enteredViaLowVoltage(enteredViaLowVoltage), .accessReq(accessReq), .wb_adr_i(wb_adr_i),
    .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .settings(settings), .accessGrant(accessGrant),
    .cfgWriteStrobe(cfgWriteStrobe), .cfgWriteValue(cfgWriteValue));
`default_nettype wire

//--- verif/cwd_nvm_model.sv
`default_nettype none
module cwd_nvm_model (
    input  wire logic        clk_sys,
    input  wire logic        cfgWriteStrobe,
    input  wire logic        progWriteSel,
    input  wire logic [13:0] cfgWriteValue,
    output var logic [13:0]  nvmWordOne,
    output var logic [13:0]  nvmWordTwo,
    output var logic         nvmBlank
);
    timeunit 1ns;
    timeprecision 1ps;
    // tools leave the debugger bit at one
    initial begin
        nvmWordOne = 14'h3FFF;
        nvmWordTwo = 14'h3FFF;
        nvmBlank = 1'b1;
    end
    task automatic load(input logic [13:0] a, input logic [13:0] b, input logic bl);
        nvmWordOne <= a;
        nvmWordTwo <= b;
        nvmBlank <= bl;
    endtask : load
    always @(posedge clk_sys) begin
        if (cfgWriteStrobe && progWriteSel) nvmWordTwo <= cfgWriteValue;
        if (cfgWriteStrobe && !progWriteSel) nvmWordOne <= cfgWriteValue;
    end
endmodule : cwd_nvm_model
`default_nettype wire

//--- verif/test_cwd_config_decode.sv
`default_nettype none
module test_cwd_config_decode;
    import cwd_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, resetn, clkEn, nvmBlank, largeMemory, lowV, pwc, pws, bulk, we, cyc, stb;
    logic ack, err, grant, rz, stro, eP, eD;
    logic [13:0] w1, w2, pwd, nw1, nw2, cwv;
    logic [31:0] adr, dat, rdat;
    cwd_access_type accessReq;
    cwd_settings_type s;
    cwd_mode_type modes[4] = '{CWD_MODE_OFF, CWD_MODE_SOFT, CWD_MODE_RUN, CWD_MODE_ON};
    int n_mismatch = 0;
    int cmp_count = 0;
    logic [2:0] b;
    logic [31:0] d;
    logic e;
    cwd_config_decode u_cwd_config_decode (.clk_sys(clk_sys), .resetn(resetn), .clkEn(clkEn),
        .nvmWordOne(nw1), .nvmWordTwo(nw2), .nvmBlank(nvmBlank), .largeMemory(largeMemory),
        .enteredViaLowVoltage(lowV), .progWriteCfg(pwc), .progWriteSel(pws),
        .progWriteData(pwd), .bulkEraseActive(bulk), .accessReq(accessReq), .wb_adr_i(adr),
        .wb_dat_i(dat), .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .settings(s), .accessGrant(grant),
        .readZero(rz), .cfgWriteStrobe(stro), .cfgWriteValue(cwv), .eraseProgram(eP),
        .eraseData(eD));
    cwd_nvm_model u_cwd_nvm_model (.clk_sys(clk_sys), .cfgWriteStrobe(stro),
        .progWriteSel(pws), .cfgWriteValue(cwv), .nvmWordOne(nw1), .nvmWordTwo(nw2),
        .nvmBlank(nvmBlank));
    // ****************************************
    // tasks
    // ****************************************
    task automatic report_and_stop;
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // answer and read data taken at the rising edge that samples ack or err
    task automatic wb(input logic w, input logic [17:0] a, output logic [31:0] rd,
        output logic er);
        @(posedge clk_sys);
        {cyc, stb, we, adr, dat} <= {2'b11, w, 14'h0, a, 32'h0000_1234};
        do @(posedge clk_sys); while (ack !== 1'b1 && err !== 1'b1);
        rd = rdat;
        er = err;
        {cyc, stb, we} <= 3'b000;
    endtask : wb
    task automatic acc(input logic w, input logic x, input logic p, input logic [12:0] a);
        @(posedge clk_sys);
        accessReq <= '{1'b1, w, x, p, a};
        @(negedge clk_sys);
    endtask : acc
    task automatic rst(input logic [13:0] a, input logic [13:0] c, input logic bl);
        @(posedge clk_sys);
        u_cwd_nvm_model.load(a, c, bl);
        resetn <= 1'b0;
        repeat (6) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (2) @(posedge clk_sys);
    endtask : rst
    initial begin
        clk_sys = 0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        #100000;
        n_mismatch++;
        report_and_stop();
    end
    // ****************************************
    // tests
    // ****************************************
    initial begin
        {resetn, lowV, pwc, pws, bulk, we, cyc, stb, largeMemory} = '0;
        clkEn = 1;
        pwd = '0;
        adr = '0;
        dat = '0;
        accessReq = '0;
        for (int i = 0; i < 8; i++) begin
            b = 3'(i);
            w1 = {b[0], b[1], b[2], b[1:0], 2'b11, b[1], b[0], b[2:1], b};
            w2 = {b[2], b[1], 1'b0, 1'b1, b[0], b[2], 2'b00, b[1:0], 2'b00, b[1:0]};
            rst(w1, w2, 1'b0);
            largeMemory <= b[2];
            chk(32'(s.clockMonitorEnable), 32'(b[0]));
            chk(32'(s.clockSwitchoverEnable), 32'(b[1]));
            chk(32'(s.clockOutputDrive), 32'(!b[2]));
            chk(32'(s.brownoutMode), 32'(modes[b[1:0]]));
            d = {29'h0, s.resetPinIsReset, s.resetPinPullup, s.resetPinPullupByControl};
            chk(d, |b[2:1] ? 32'h6 : 32'h1);
            d = {28'h0, s.lowVoltageProgramEnable, s.brownoutLevelSelect, s.programProtect,
                 s.dataProtect};
            chk(d, {28'h0, b[2], 3'b100});
            chk(32'(s.regulatorCapPin), &b[1:0] ? 32'h0 : 32'h1 << b[1:0]);
            chk(32'(s.powerupTimerOn), 32'(!b[0]));
            chk(32'(s.watchdogMode), 32'(modes[b[2:1]]));
            chk(32'(s.oscillatorSource), 32'h1 << i);
            chk(32'(s.stackFaultResetEnable), 32'(b[0]));
            chk(32'(s.multiplierEnable), 32'(b[2]));
            chk(32'(s.debuggerOwnsPins), 32'(!b[1]));
            wb(1'b0, CWD_ADR_CFG1, d, e);
            chk(d, {18'h0, w1});
            wb(1'b0, CWD_ADR_CFG2, d, e);
            chk(d, {18'h0, w2 | CWD_C2_UNIMPL});
            acc(1'b1, 1'b0, 1'b1, 13'h0200);
            chk(32'(grant), 32'(b[1]));
            acc(1'b1, 1'b0, 1'b1, b[2] ? 13'h1000 : 13'h0800);
            chk(32'(grant), 32'(|b[1:0]));
        end
        rst(14'h3E7F, 14'h3FFF, 1'b0);
        chk(32'({s.programProtect, s.dataProtect}), 32'h3);
        acc(1'b0, 1'b1, 1'b1, 13'h0010);
        chk({grant, rz}, 32'h3);
        acc(1'b1, 1'b1, 1'b1, 13'h0010);
        chk(32'(grant), 32'h0);
        acc(1'b0, 1'b1, 1'b0, 13'h0004);
        chk(32'(grant), 32'h0);
        acc(1'b1, 1'b1, 1'b0, 13'h0004);
        chk(32'(grant), 32'h0);
        acc(1'b1, 1'b0, 1'b0, 13'h0004);
        chk(32'(grant), 32'h1);
        acc(1'b0, 1'b0, 1'b1, 13'h0010);
        chk({grant, rz}, 32'h2);
        @(posedge clk_sys);
        {pwc, pws, pwd, accessReq} <= {2'b10, 14'h3FFF, 17'h0};
        @(negedge clk_sys);
        chk({stro, eP, eD}, 32'h6);
        @(posedge clk_sys);
        bulk <= 1'b1;
        @(negedge clk_sys);
        chk({eP, eD}, 32'h3);
        @(posedge clk_sys);
        {bulk, pws, lowV, pwd} <= {3'b011, 14'h0000};
        @(negedge clk_sys);
        chk({stro, cwv}, {17'h0, 1'b1, 14'h2000 | CWD_C2_UNIMPL});
        @(posedge clk_sys);
        pwc <= 1'b0;
        wb(1'b0, CWD_ADR_CFG1, d, e);
        chk(d, 32'h0000_3E7F);
        wb(1'b0, CWD_ADR_IDENT, d, e);
        chk(d, {18'h0, CWD_PART_CODE, CWD_REV_CODE});
        wb(1'b1, CWD_ADR_IDENT, d, e);
        chk(32'(e), 32'h1);
        wb(1'b0, 18'h00100, d, e);
        chk(32'(e), 32'h1);
        wb(1'b0, CWD_ADR_STAT, d, e);
        chk(32'(d[0]), 32'h1);
        // load must wait for the enable
        @(posedge clk_sys);
        clkEn <= 1'b0;
        rst(14'h0000, 14'h0000, 1'b1);
        acc(1'b0, 1'b0, 1'b1, 13'h0004);
        chk(32'(grant), 32'h0);
        @(posedge clk_sys);
        clkEn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk(32'(grant), 32'h1);
        chk(32'(s.oscillatorSource), 32'(CWD_OSC_ECH));
        wb(1'b0, CWD_ADR_CFG2, d, e);
        chk(d, 32'h0000_3FFF);
        report_and_stop();
    end
endmodule : test_cwd_config_decode
`default_nettype wire
